// ---- logic/pwmag_pkg.sv ----
// Package with register map, field positions and action codes of the PWM action generator
`default_nettype none
package pwmag_pkg;
   localparam int PWMAG_NUM_GEN = 3;
   localparam int PWMAG_CNT_W = 16;
   localparam int PWMAG_ADDR_W = 12;
   // Register byte addresses
   localparam logic [11:0] PWMAG_GEN0_OUT_A_ACTIONS = 12'h060;
   localparam logic [11:0] PWMAG_GEN0_OUT_B_ACTIONS = 12'h064;
   localparam logic [11:0] PWMAG_GEN1_OUT_A_ACTIONS = 12'h0a0;
   localparam logic [11:0] PWMAG_GEN1_OUT_B_ACTIONS = 12'h0a4;
   localparam logic [11:0] PWMAG_GEN2_OUT_A_ACTIONS = 12'h0e0;
   localparam logic [11:0] PWMAG_GEN2_OUT_B_ACTIONS = 12'h0e4;
   // Action field positions (low bit of each two-bit field)
   localparam int PWMAG_ON_ZERO_POS = 0;
   localparam int PWMAG_ON_RELOAD_POS = 2;
   localparam int PWMAG_FIRST_RISE_POS = 4;
   localparam int PWMAG_FIRST_FALL_POS = 6;
   localparam int PWMAG_SECOND_RISE_POS = 8;
   localparam int PWMAG_SECOND_FALL_POS = 10;
   localparam int PWMAG_FIELD_W = 12;
   // Reset values and up/down mode code
   localparam logic [11:0] PWMAG_ACTIONS_RESET = 12'h000;
   localparam logic PWMAG_OUT_RESET = 1'b0;
   localparam logic PWMAG_MODE_UPDOWN = 1'b1;
   // Action codes
   localparam logic [1:0] PWMAG_ACT_NONE = 2'h0;
   localparam logic [1:0] PWMAG_ACT_INVERT = 2'h1;
   localparam logic [1:0] PWMAG_ACT_LOW = 2'h2;
   localparam logic [1:0] PWMAG_ACT_HIGH = 2'h3;
endpackage
`default_nettype wire

// ---- logic/pwmag_top.sv ----
// PWM output action generator for three generators with an APB register slave
// How it works
// - Each generator derives zero, load and four comparator events; down mode has two.
// - Action code 0 keeps, 1 inverts, 2 drives low, 3 drives high the output.
// - Bits 1:0 choose the action when the counter reaches zero.
// - Bits 3:2 choose the action when the counter equals the load value.
// - Bits 5:4 act on comparator A match counting up, only in up/down mode.
// - Bits 7:6 act on comparator A match counting down.
// - Bits 9:8 act on comparator B match counting up, only in up/down mode.
// - Bits 11:10 act on comparator B match counting down.
// - Zero or load events override any coinciding comparator event.
// - On the A output comparator A wins over comparator B.
// - On the B output comparator B wins over comparator A.
// - Each generator has separate A and B action registers driving only their own output.
// - A comparator programmed above the load value never matches.
//
// Added by the designer: the APB slave port.
`default_nettype none
module pwmag_top
   import pwmag_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Counter and comparator state per generator
   input wire logic [2:0] i_count_tick,
   input wire logic [2:0] i_count_up,
   input wire logic [2:0] i_updown_mode,
   input wire logic [2:0][15:0] i_counter,
   input wire logic [2:0][15:0] i_period_reload_value,
   input wire logic [2:0][15:0] i_first_compare,
   input wire logic [2:0][15:0] i_second_compare,
   // PWM outputs
   output logic [2:0] o_generator_output_first,
   output logic [2:0] o_generator_output_second
);

   // Action registers and bus decode
   logic [11:0] actions_a [PWMAG_NUM_GEN];
   logic [11:0] actions_b [PWMAG_NUM_GEN];
   logic access;
   logic done;
   logic rd_strobe;
   logic wr_strobe;
   logic [2:0] wr_a;
   logic [2:0] wr_b;
   logic hit;
   logic [11:0] rd_field;
   // Events and next output levels
   logic [2:0] ev_zero;
   logic [2:0] ev_load;
   logic [2:0] ev_a_up;
   logic [2:0] ev_a_dn;
   logic [2:0] ev_b_up;
   logic [2:0] ev_b_dn;
   logic [2:0] next_out_a;
   logic [2:0] next_out_b;

   // Apply a two-bit action code to the current output level
   function automatic logic pwmag_apply(input logic [1:0] act, input logic cur);
      logic res;
      res = cur;
      unique case (act)
         PWMAG_ACT_NONE: res = cur;
         PWMAG_ACT_INVERT: res = ~cur;
         PWMAG_ACT_LOW: res = 1'b0;
         PWMAG_ACT_HIGH: res = 1'b1;
      endcase
      return res;
   endfunction

   // Comparator match, blocked when the compare value lies above the load value
   function automatic logic pwmag_match(input logic tick, input logic [15:0] cnt, input logic [15:0] cmp,
                                        input logic [15:0] ld);
      logic same;
      same = tick && (cnt == cmp);
      return same && (cmp <= ld);
   endfunction

   // Pick the action that wins for one output, given its events and preference
   function automatic logic [1:0] pwmag_select(input logic [11:0] f, input logic zero, input logic load,
                                               input logic a_up, input logic a_dn, input logic b_up,
                                               input logic b_dn, input logic prefer_b);
      logic [1:0] act;
      logic [1:0] act_a;
      logic [1:0] act_b;
      logic a_ev;
      logic b_ev;
      act = PWMAG_ACT_NONE;
      act_a = a_up ? f[PWMAG_FIRST_RISE_POS +: 2] : f[PWMAG_FIRST_FALL_POS +: 2];
      act_b = b_up ? f[PWMAG_SECOND_RISE_POS +: 2] : f[PWMAG_SECOND_FALL_POS +: 2];
      a_ev = a_up | a_dn;
      b_ev = b_up | b_dn;
      if (zero)
      begin
         act = f[PWMAG_ON_ZERO_POS +: 2];
      end
      else if (load)
      begin
         act = f[PWMAG_ON_RELOAD_POS +: 2];
      end
      else if (a_ev && b_ev)
      begin
         act = prefer_b ? act_b : act_a;
      end
      else if (a_ev)
      begin
         act = act_a;
      end
      else if (b_ev)
      begin
         act = act_b;
      end
      return act;
   endfunction

   // Zero and load events from the counter state of each generator
   always_comb
   begin
      for (int g = 0; g < PWMAG_NUM_GEN; g++)
      begin
         ev_zero[g] = i_count_tick[g] && (i_counter[g] == 16'h0000);
         ev_load[g] = i_count_tick[g] && (i_counter[g] == i_period_reload_value[g]);
      end
   end

   // Comparator events; rising ones only while up/down mode counts up
   always_comb
   begin
      logic a_match;
      logic b_match;
      logic up_ok;
      a_match = 1'b0;
      b_match = 1'b0;
      up_ok = 1'b0;
      for (int g = 0; g < PWMAG_NUM_GEN; g++)
      begin
         a_match = pwmag_match(i_count_tick[g], i_counter[g], i_first_compare[g], i_period_reload_value[g]);
         b_match = pwmag_match(i_count_tick[g], i_counter[g], i_second_compare[g], i_period_reload_value[g]);
         up_ok = (i_updown_mode[g] == PWMAG_MODE_UPDOWN) && i_count_up[g];
         ev_a_up[g] = a_match && up_ok;
         ev_a_dn[g] = a_match && !up_ok;
         ev_b_up[g] = b_match && up_ok;
         ev_b_dn[g] = b_match && !up_ok;
      end
   end

   // Next levels of the first outputs, each from its own A register only
   always_comb
   begin
      for (int g = 0; g < PWMAG_NUM_GEN; g++)
      begin
         next_out_a[g] = pwmag_apply(pwmag_select(actions_a[g], ev_zero[g], ev_load[g], ev_a_up[g],
                                     ev_a_dn[g], ev_b_up[g], ev_b_dn[g], 1'b0),
                                     o_generator_output_first[g]);
      end
   end

   // Next levels of the second outputs, each from its own B register only
   always_comb
   begin
      for (int g = 0; g < PWMAG_NUM_GEN; g++)
      begin
         next_out_b[g] = pwmag_apply(pwmag_select(actions_b[g], ev_zero[g], ev_load[g], ev_a_up[g],
                                     ev_a_dn[g], ev_b_up[g], ev_b_dn[g], 1'b1),
                                     o_generator_output_second[g]);
      end
   end

   // First output flip-flops hold their level between events
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_generator_output_first <= {3{PWMAG_OUT_RESET}};
      end
      else if (i_clk_en)
      begin
         o_generator_output_first <= next_out_a;
      end
   end

   // Second output flip-flops, kept apart so one output never disturbs the other
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_generator_output_second <= {3{PWMAG_OUT_RESET}};
      end
      else if (i_clk_en)
      begin
         o_generator_output_second <= next_out_b;
      end
   end

   // Address decode of the six action registers
   always_comb
   begin
      wr_a = 3'h0;
      wr_b = 3'h0;
      hit = 1'b1;
      rd_field = 12'h000;
      unique case (i_paddr)
         PWMAG_GEN0_OUT_A_ACTIONS:
         begin
            wr_a[0] = 1'b1;
            rd_field = actions_a[0];
         end
         PWMAG_GEN0_OUT_B_ACTIONS:
         begin
            wr_b[0] = 1'b1;
            rd_field = actions_b[0];
         end
         PWMAG_GEN1_OUT_A_ACTIONS:
         begin
            wr_a[1] = 1'b1;
            rd_field = actions_a[1];
         end
         PWMAG_GEN1_OUT_B_ACTIONS:
         begin
            wr_b[1] = 1'b1;
            rd_field = actions_b[1];
         end
         PWMAG_GEN2_OUT_A_ACTIONS:
         begin
            wr_a[2] = 1'b1;
            rd_field = actions_a[2];
         end
         PWMAG_GEN2_OUT_B_ACTIONS:
         begin
            wr_b[2] = 1'b1;
            rd_field = actions_b[2];
         end
         default: hit = 1'b0;
      endcase
   end

   // One wait state: ready rises in the second access cycle
   assign access = i_psel && i_penable;
   assign done = access && o_pready;

   // Read data is caught in the first access cycle, a write lands at the completing edge
   assign rd_strobe = access && !o_pready && !i_pwrite;
   assign wr_strobe = done && i_pwrite;

   // Handshake flip-flops; an unmapped address answers with an error
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_pready <= access && !o_pready;
         o_pslverr <= access && !o_pready && !hit;
      end
   end

   // Read data flip-flops; upper read bits are zero
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_prdata <= 32'h0000_0000;
      end
      else if (i_clk_en && rd_strobe)
      begin
         o_prdata <= {20'h00000, rd_field};
      end
   end

   // Action registers, written at the completing edge of a write
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         for (int g = 0; g < PWMAG_NUM_GEN; g++)
         begin
            actions_a[g] <= PWMAG_ACTIONS_RESET;
            actions_b[g] <= PWMAG_ACTIONS_RESET;
         end
      end
      else if (i_clk_en && wr_strobe)
      begin
         for (int g = 0; g < PWMAG_NUM_GEN; g++)
         begin
            if (wr_a[g])
            begin
               actions_a[g] <= i_pwdata[PWMAG_FIELD_W-1:0];
            end
            if (wr_b[g])
            begin
               actions_b[g] <= i_pwdata[PWMAG_FIELD_W-1:0];
            end
         end
      end
   end

endmodule // pwmag_top
`default_nettype wire

// ---- tb/pwmag_properties.sv ----
// Checker of output actions and bus timing of the PWM action generator
`default_nettype none
module pwmag_properties
   import pwmag_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [2:0] i_count_tick,
   input wire logic [2:0][15:0] i_counter,
   input wire logic [2:0][15:0] i_period_reload_value,
   input wire logic [2:0][15:0] i_first_compare,
   input wire logic [2:0][15:0] i_second_compare,
   input wire logic [2:0] o_generator_output_first,
   input wire logic [2:0] o_generator_output_second
);
   logic [11:0] act;
   wire tk = i_count_tick[0] && i_clk_en;
   wire [15:0] cn = i_counter[0];
   wire [15:0] ld = i_period_reload_value[0];
   wire out = o_generator_output_first[0];
   // Mirror of the generator 0 A action register, taken at the completing bus edge
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         act <= '0;
      end
      else if (i_clk_en && i_psel && i_penable && o_pready && i_pwrite && i_paddr == PWMAG_GEN0_OUT_A_ACTIONS)
      begin
         act <= i_pwdata[11:0];
      end
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   // Output actions of generator 0 A, hold of generator 1 B output, and bus answer timing
   AST_ZERO_HIGH: assert property (tk && cn == 0 && act[1:0] == PWMAG_ACT_HIGH |=> out)
      else $error("zero action high not applied");
   AST_ZERO_LOW: assert property (tk && cn == 0 && act[1:0] == PWMAG_ACT_LOW |=> !out)
      else $error("zero action low not applied");
   AST_ZERO_INV: assert property (tk && cn == 0 && act[1:0] == PWMAG_ACT_INVERT |=> out != $past(out))
      else $error("zero action invert not applied");
   AST_LOAD_HIGH: assert property (tk && cn == ld && cn != 0 && act[3:2] == PWMAG_ACT_HIGH |=> out)
      else $error("load action high not applied");
   AST_HOLD_A: assert property (!tk |=> $stable(out))
      else $error("output moved without an event");
   AST_HOLD_B: assert property (!(i_count_tick[1] && i_clk_en) |=> $stable(o_generator_output_second[1]))
      else $error("second output moved without its own event");
   AST_NO_MATCH: assert property (tk && cn != 0 && cn != ld && i_first_compare[0] > ld
      && i_second_compare[0] > ld |=> $stable(out))
      else $error("compare above load acted");
   AST_PREADY: assert property (i_psel && i_penable && !o_pready && i_clk_en |=> o_pready ##1 !o_pready)
      else $error("bus answer not one cycle after access");
   // Main scenarios reached
   cover property (tk && cn == 0);
   cover property (o_pslverr);
   cover property (o_pready && !o_pslverr);
endmodule // pwmag_properties
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking testbench of the PWM action generator
`default_nettype none
module testbench
   import pwmag_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_mclk = 0, i_sys_rst = 1, i_clk_en = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, ps;
   logic [11:0] i_paddr = '0;
   logic [31:0] i_pwdata = '0, o_prdata, rd;
   logic o_pready, o_pslverr;
   logic [2:0] i_count_tick = '0, i_count_up = '0, i_updown_mode = '0;
   logic [2:0] o_generator_output_first, o_generator_output_second;
   logic [2:0][15:0] i_counter = '0, i_period_reload_value = {3{16'h0064}};
   logic [2:0][15:0] i_first_compare = {3{16'h0028}}, i_second_compare = {3{16'h003c}};
   int error_cnt = 0, n_tests = 0, cyc = 0;
   pwmag_top dut (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_clk_en(i_clk_en),
      .i_psel(i_psel),
      .i_penable(i_penable),
      .i_pwrite(i_pwrite),
      .i_paddr(i_paddr),
      .i_pwdata(i_pwdata),
      .o_prdata(o_prdata),
      .o_pready(o_pready),
      .o_pslverr(o_pslverr),
      .i_count_tick(i_count_tick),
      .i_count_up(i_count_up),
      .i_updown_mode(i_updown_mode),
      .i_counter(i_counter),
      .i_period_reload_value(i_period_reload_value),
      .i_first_compare(i_first_compare),
      .i_second_compare(i_second_compare),
      .o_generator_output_first(o_generator_output_first),
      .o_generator_output_second(o_generator_output_second)
   );
   // Clock and hang guard
   always #5 i_mclk = ~i_mclk;
   always @(posedge i_mclk)
      if (++cyc > 3000)
      begin
         error_cnt++;
         tally_and_finish();
      end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bus transfer: hold the request until pready is seen at a rising edge, then one idle cycle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      @(posedge i_mclk);
      while (o_pready !== 1'b1)
      begin
         @(posedge i_mclk);
      end
      rd = o_prdata;
      ps = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_mclk);
   endtask
   // One counter event on the generators in mask t
   task automatic ev(input logic [2:0] t, input logic [15:0] c, input logic m, input logic u);
      i_counter <= {3{c}};
      i_updown_mode <= {3{m}};
      i_count_up <= {3{u}};
      i_count_tick <= t;
      @(posedge i_mclk);
      i_count_tick <= '0;
      @(posedge i_mclk);
   endtask
   task automatic t_regs;
      logic [11:0] adr [6] = '{PWMAG_GEN0_OUT_A_ACTIONS, PWMAG_GEN0_OUT_B_ACTIONS, PWMAG_GEN1_OUT_A_ACTIONS,
         PWMAG_GEN1_OUT_B_ACTIONS, PWMAG_GEN2_OUT_A_ACTIONS, PWMAG_GEN2_OUT_B_ACTIONS};
      chk({o_generator_output_first, o_generator_output_second}, '0);
      foreach (adr[i])
      begin
         apb(1'b0, adr[i], '0);
         chk(rd, '0);
         apb(1'b1, adr[i], '1);
         apb(1'b0, adr[i], '0);
         chk(rd, 32'h0000_0fff);
      end
   endtask
   task automatic t_fields;
      logic [15:0] c [6] = '{16'h0000, 16'h0064, 16'h0028, 16'h0028, 16'h003c, 16'h003c};
      for (int f = 0; f < 6; f++)
         for (int v = 2; v < 4; v++)
         begin
            apb(1'b1, PWMAG_GEN0_OUT_A_ACTIONS, 32'(v) << (2 * f));
            ev(3'h1, c[f], 1'b1, f[0] == 1'b0);
            chk(o_generator_output_first[0], v == 3);
         end
      apb(1'b1, PWMAG_GEN0_OUT_A_ACTIONS, 32'h0000_0031);
      ev(3'h1, 16'h0000, 1'b0, 1'b0);
      chk(o_generator_output_first[0], 1'b0);
      ev(3'h1, 16'h0028, 1'b0, 1'b1);
      chk(o_generator_output_first[0], 1'b0);
   endtask
   task automatic t_prio;
      i_first_compare <= '0;
      apb(1'b1, PWMAG_GEN0_OUT_A_ACTIONS, 32'h0000_00c0);
      ev(3'h1, 16'h0000, 1'b1, 1'b0);
      chk(o_generator_output_first[0], 1'b0);
      i_first_compare <= {3{16'h003c}};
      apb(1'b1, PWMAG_GEN0_OUT_A_ACTIONS, 32'h0000_08c0);
      apb(1'b1, PWMAG_GEN0_OUT_B_ACTIONS, 32'h0000_0c80);
      ev(3'h1, 16'h003c, 1'b1, 1'b0);
      chk({o_generator_output_first[0], o_generator_output_second[0]}, 2'h3);
      apb(1'b1, PWMAG_GEN2_OUT_A_ACTIONS, '0);
      ev(3'h6, 16'h0000, 1'b1, 1'b0);
      chk({o_generator_output_first, o_generator_output_second}, 6'h1f);
   endtask
   task automatic t_misc;
      // Unmapped address: error answer, read data zero, write dropped
      apb(1'b0, 12'h068, '0);
      chk(ps, 1'b1);
      chk(rd, '0);
      apb(1'b1, 12'h068, '1);
      chk(ps, 1'b1);
      apb(1'b0, PWMAG_GEN0_OUT_B_ACTIONS, '0);
      chk(ps, 1'b0);
      chk(rd, 32'h0000_0c80);
      i_first_compare <= {3{16'h00c8}};
      i_second_compare <= {3{16'h00c8}};
      apb(1'b1, PWMAG_GEN0_OUT_A_ACTIONS, 32'h0000_0aa0);
      ev(3'h1, 16'h00c8, 1'b1, 1'b0);
      chk(o_generator_output_first[0], 1'b1);
      // Clock enable low freezes the outputs, then the invert lands
      apb(1'b1, PWMAG_GEN0_OUT_A_ACTIONS, 32'h0000_0001);
      i_clk_en <= 1'b0;
      ev(3'h1, 16'h0000, 1'b1, 1'b0);
      chk(o_generator_output_first[0], 1'b1);
      i_clk_en <= 1'b1;
      ev(3'h1, 16'h0000, 1'b1, 1'b0);
      chk(o_generator_output_first[0], 1'b0);
      // Reset in mid-run clears outputs and action registers
      i_sys_rst <= 1'b1;
      @(posedge i_mclk);
      chk({o_generator_output_first, o_generator_output_second}, '0);
      i_sys_rst <= 1'b0;
      @(posedge i_mclk);
      apb(1'b0, PWMAG_GEN0_OUT_B_ACTIONS, '0);
      chk(rd, '0);
   endtask
   task automatic tally_and_finish;
      if (error_cnt == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (4) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      @(posedge i_mclk);
      t_regs();
      t_fields();
      t_prio();
      t_misc();
      tally_and_finish();
   end
endmodule // testbench
bind pwmag_top pwmag_properties u_chk (
   .i_mclk(i_mclk),
   .i_sys_rst(i_sys_rst),
   .i_clk_en(i_clk_en),
   .i_psel(i_psel),
   .i_penable(i_penable),
   .i_pwrite(i_pwrite),
   .i_paddr(i_paddr),
   .i_pwdata(i_pwdata),
   .o_pready(o_pready),
   .o_pslverr(o_pslverr),
   .i_count_tick(i_count_tick),
   .i_counter(i_counter),
   .i_period_reload_value(i_period_reload_value),
   .i_first_compare(i_first_compare),
   .i_second_compare(i_second_compare),
   .o_generator_output_first(o_generator_output_first),
   .o_generator_output_second(o_generator_output_second)
);
`default_nettype wire
